// File: lfptr_top.sv
// Purpose: LF wakeup receiver control and telegram baseband behind an AXI4-Lite slave
// Assumes: Comparator and carrier detect arrive asynchronously from the analog front end
// Notes:   Registers are 8 bits in the low byte lane of one aligned word each
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "lfptr_defines.svh"

// Notes on behaviour
// R1: software sets dynamic threshold field to 01
// R2: calibration enable calibrates at each power-up
// R3: freeze bit holds threshold after calibration
// R4: software writes zero to reserved bit
// R5: timer enable cycles front end on/off
// R6: readable on/off status of receiver
// R7: timebase tick every N+1 oscillator periods
// R8: off phase lasts (F+1)*4 timebase ticks
// R9: on phase lasts (T+1)*(N/4+1) periods
// R10: baseband switched by enable or timer
// R11: mode 1 always, mode 2 after carrier
// R12: telegram is preamble, sync, ID, payload
// R13: ID compared against two stored patterns
// R14: software drains data before overflow
// R15: sync matcher watches 18 raw chips
// R16: sync match sets flag, wakes CPU
// R17: raw comparator level readable by software
// R18: first 8/16 bits after sync are ID
// R19: decode until violation or baseband off
// R20: violation sets error, clears sync flag
// R21: transmitter sends equal-value preamble
// R22: recalibrate bit starts calibration on demand
// R23: pattern length bit selects 8 or 16
// R24: timer starts on, alternates, status tracks
// R25: chip pair without transition is violation
module lfptr_top #(
  parameter int LP_CYCLES   = `LFPTR_LP_CYCLES,
  parameter int CHIP_CYCLES = `LFPTR_CHIP_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        raw_comparator_in,
  input  wire logic        carrier_detect_in,
  output logic             frontend_on,
  output logic             calib_start,
  output logic             threshold_freeze,
  output logic [1:0]       dynamic_threshold_sel,
  output logic             baseband_active,
  output logic             wakeup_pulse
);
  import lfptr_pkg::*;

  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  // Registers and state
  logic [7:0]  cdm_reg, precnt_reg, onoff_reg, pcfg_reg;
  logic [7:0]  pat_reg [0:3];
  lfptr_rxc_s  rxc_reg;
  logic        decode_error_flag_reg, sync_reg, match_reg, drdy_reg, ovf_reg;
  logic [7:0]  data_reg;
  logic [1:0]  raw_sync_reg, cd_sync_reg;
  logic        carrier_seen_reg, power_q_reg;
  logic [15:0] lp_cnt_reg, chip_cnt_reg;
  logic        id_phase_reg;
  logic [3:0]  bit_cnt_reg;
  logic [15:0] id_shift_reg;
  logic [7:0]  byte_shift_reg;
  logic [9:0]  aw_addr_reg;
  logic [7:0]  w_data_reg;
  logic        aw_held_reg, w_held_reg, w_lane_reg;

  // Combinational
  logic        lp_tick, chip_tick, on_phase, rx_power;
  logic        wr_fire, rd_fire, wr_hit, rd_data_hit;
  logic [7:0]  wr_idx, rd_idx, rd_byte;
  logic        rd_ok, wr_ok;
  logic        id_last, id_match, recal_wr, st_wr, w1c_sync, w1c_err, w1c_match, w1c_ovf;
  logic [15:0] id_next;
  lfptr_dec_s  dec;

  // Pin inputs pass two flops; stage one feeds only stage two
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      raw_sync_reg <= 2'b00;
      cd_sync_reg  <= 2'b00;
    end else begin
      raw_sync_reg <= {raw_sync_reg[0], raw_comparator_in};
      cd_sync_reg  <= {cd_sync_reg[0], carrier_detect_in};
    end
  end

  // Low-power oscillator period and chip time as enable pulses
  assign lp_tick   = (lp_cnt_reg == 16'(LP_CYCLES - 1));
  assign chip_tick = (chip_cnt_reg == 16'(CHIP_CYCLES - 1));

  always_ff @(posedge sys_clk) begin
    if (sys_rst || lp_tick) begin
      lp_cnt_reg <= 16'h0000;
    end else begin
      lp_cnt_reg <= lp_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || chip_tick) begin
      chip_cnt_reg <= 16'h0000;
    end else begin
      chip_cnt_reg <= chip_cnt_reg + 16'h0001;
    end
  end

  lfptr_poll_timer u_timer (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .lp_tick  (lp_tick),
    .enable   (rxc_reg.timer_en),
    .precount (precnt_reg),
    .on_time  (onoff_reg[3:0]),
    .off_time (onoff_reg[7:4]),
    .on_phase (on_phase)
  );

  assign rx_power = rxc_reg.timer_en ? on_phase : rxc_reg.rx_en; // R10

  // Carrier must be seen again after every power-up before mode 2 runs
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !rx_power) begin
      carrier_seen_reg <= 1'b0;
    end else if (cd_sync_reg[1]) begin
      carrier_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      frontend_on     <= 1'b0;
      power_q_reg     <= 1'b0;
      calib_start     <= 1'b0;
      baseband_active <= 1'b0;
    end else begin
      frontend_on <= rx_power; // R5
      power_q_reg <= rx_power;
      calib_start <= (rx_power && !power_q_reg && cdm_reg[`LFPTR_CDM_CAL]) || recal_wr; // R2 R22
      unique case (rxc_reg.bbm)
        LFPTR_BBM_ALWAYS:  baseband_active <= rx_power; // R11
        LFPTR_BBM_CARRIER: baseband_active <= rx_power && carrier_seen_reg; // R11
        default:           baseband_active <= 1'b0;
      endcase
    end
  end

  assign threshold_freeze      = cdm_reg[`LFPTR_CDM_FREEZE]; // R3
  assign dynamic_threshold_sel = cdm_reg[`LFPTR_CDM_DYN_HI:`LFPTR_CDM_DYN_LO];

  lfptr_decoder u_dec (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .chip_tick (chip_tick),
    .raw       (raw_sync_reg[1]),
    .active    (baseband_active), // R19
    .dec       (dec)
  );

  // Identifier and payload assembly
  assign id_next  = {id_shift_reg[14:0], dec.bit_value};
  assign id_last  = bit_cnt_reg == (pcfg_reg[`LFPTR_PCFG_PSL] ? 4'hF : 4'h7); // R23
  assign id_match = pcfg_reg[`LFPTR_PCFG_PSL] ?
                    (id_next == {pat_reg[1], pat_reg[0]} ||
                     (pcfg_reg[`LFPTR_PCFG_PSEL] && id_next == {pat_reg[3], pat_reg[2]})) :
                    (id_next[7:0] == pat_reg[0] ||
                     (pcfg_reg[`LFPTR_PCFG_PSEL] && id_next[7:0] == pat_reg[2])); // R13

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      id_phase_reg   <= 1'b0;
      bit_cnt_reg    <= 4'h0;
      id_shift_reg   <= 16'h0000;
      byte_shift_reg <= 8'h00;
    end else if (dec.sync_hit) begin
      id_phase_reg <= !pcfg_reg[`LFPTR_PCFG_SYNM]; // R18
      bit_cnt_reg  <= 4'h0;
    end else if (dec.bit_valid && id_phase_reg) begin
      id_shift_reg <= id_next; // R18
      bit_cnt_reg  <= id_last ? 4'h0 : bit_cnt_reg + 4'h1;
      id_phase_reg <= !id_last;
    end else if (dec.bit_valid) begin
      byte_shift_reg <= {byte_shift_reg[6:0], dec.bit_value};
      bit_cnt_reg    <= {1'b0, bit_cnt_reg[2:0] + 3'h1};
    end
  end

  // Status flags: hardware set wins over a software clear in the same cycle
  assign st_wr     = wr_hit && wr_idx == `LFPTR_IDX_STATUS;
  assign w1c_sync  = st_wr && w_data_reg[`LFPTR_ST_SYNC];
  assign w1c_err   = st_wr && w_data_reg[`LFPTR_ST_DECODE_ERROR_FLAG];
  assign w1c_match = st_wr && w_data_reg[`LFPTR_ST_MATCH];
  assign w1c_ovf   = st_wr && w_data_reg[`LFPTR_ST_OVF];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_reg     <= 1'b0;
      decode_error_flag_reg   <= 1'b0;
      match_reg    <= 1'b0;
      ovf_reg      <= 1'b0;
      drdy_reg     <= 1'b0;
      data_reg     <= 8'h00;
      wakeup_pulse <= 1'b0;
    end else begin
      if (dec.sync_hit) sync_reg <= 1'b1; // R16
      else if (dec.violation || w1c_sync) sync_reg <= 1'b0; // R20
      if (dec.violation) decode_error_flag_reg <= 1'b1; // R20
      else if (w1c_err) decode_error_flag_reg <= 1'b0;
      if (dec.bit_valid && id_phase_reg && id_last && id_match) match_reg <= 1'b1; // R13
      else if (w1c_match) match_reg <= 1'b0;
      wakeup_pulse <= dec.sync_hit || (dec.bit_valid && id_phase_reg && id_last && id_match); // R16 R18
      if (dec.bit_valid && !id_phase_reg && bit_cnt_reg[2:0] == 3'h7) begin
        data_reg <= {byte_shift_reg[6:0], dec.bit_value}; // R19
        drdy_reg <= 1'b1;
        if (drdy_reg && !rd_data_hit) ovf_reg <= 1'b1;
      end else if (rd_data_hit) begin
        drdy_reg <= 1'b0;
      end
      if (w1c_ovf && !(dec.bit_valid && drdy_reg)) ovf_reg <= 1'b0;
    end
  end

  // AXI4-Lite write: address and data taken in either order, response after both
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_idx        = aw_addr_reg[9:2];
  assign wr_ok         = wr_idx == `LFPTR_IDX_CDM || wr_idx == `LFPTR_IDX_STATUS ||
                         wr_idx == `LFPTR_IDX_DATA || (wr_idx >= `LFPTR_IDX_RXC && wr_idx <= `LFPTR_IDX_PAT1H);
  assign wr_hit        = wr_fire && wr_ok && w_lane_reg;
  assign recal_wr      = wr_hit && wr_idx == `LFPTR_IDX_RXC && w_data_reg[`LFPTR_RXC_RECAL]; // R22

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= 10'h000;
      w_data_reg   <= 8'h00;
      w_lane_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cdm_reg    <= `LFPTR_RST_CDM;
      precnt_reg <= `LFPTR_RST_PRECNT;
      onoff_reg  <= `LFPTR_RST_ONOFF;
      pcfg_reg   <= `LFPTR_RST_PCFG;
      rxc_reg    <= '0;
    end else if (wr_hit) begin
      unique case (wr_idx)
        `LFPTR_IDX_CDM:    cdm_reg <= w_data_reg & 8'h3C; // R2 R3
        `LFPTR_IDX_PRECNT: precnt_reg <= w_data_reg; // R7
        `LFPTR_IDX_ONOFF:  onoff_reg <= w_data_reg;
        `LFPTR_IDX_PCFG:   pcfg_reg <= w_data_reg & 8'h13; // R23
        `LFPTR_IDX_RXC:    rxc_reg <= {w_data_reg[`LFPTR_RXC_TIMER], w_data_reg[`LFPTR_RXC_RXEN],
                                       lfptr_bbm_e'(w_data_reg[`LFPTR_RXC_BBM_HI:`LFPTR_RXC_BBM_LO])};
        default:           ;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pat
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          pat_reg[gi] <= `LFPTR_RST_PAT;
        end else if (wr_hit && wr_idx == `LFPTR_IDX_PAT0L + 8'(gi)) begin
          pat_reg[gi] <= w_data_reg; // R13
        end
      end
    end
  endgenerate

  // AXI4-Lite read
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_idx        = s_axi_araddr[9:2];
  assign rd_data_hit   = rd_fire && rd_idx == `LFPTR_IDX_DATA;

  always_comb begin
    rd_ok   = 1'b1;
    rd_byte = 8'h00;
    if (rd_idx >= `LFPTR_IDX_PAT0L && rd_idx <= `LFPTR_IDX_PAT1H) begin
      rd_byte = pat_reg[rd_idx[1:0]];
    end else begin
      unique case (rd_idx)
        `LFPTR_IDX_CDM:    rd_byte = cdm_reg;
        `LFPTR_IDX_PRECNT: rd_byte = precnt_reg;
        `LFPTR_IDX_ONOFF:  rd_byte = onoff_reg;
        `LFPTR_IDX_PCFG:   rd_byte = pcfg_reg;
        `LFPTR_IDX_RXC:    rd_byte = {2'b00, rxc_reg.bbm, rxc_reg.timer_en, rxc_reg.rx_en,
                                      1'b0, frontend_on}; // R6 R24
        `LFPTR_IDX_STATUS: rd_byte = {1'b0, decode_error_flag_reg, raw_sync_reg[1], 1'b0, ovf_reg, drdy_reg,
                                      sync_reg, match_reg}; // R17
        `LFPTR_IDX_DATA:   rd_byte = data_reg;
        default:           rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OK;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_ok ? RESP_OK : RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// File: lfptr_defines.svh
// Purpose: Register indices, fields, resets and timing counts of the LF receiver
// Assumes: Byte address of a register is four times its index
// Notes:   Included by the top module, the decoder and the front end model
`ifndef LFPTR_DEFINES_SVH
`define LFPTR_DEFINES_SVH

`define LFPTR_IDX_CDM        8'hB5
`define LFPTR_IDX_RXC        8'hC4
`define LFPTR_IDX_PRECNT     8'hC5
`define LFPTR_IDX_ONOFF      8'hC6
`define LFPTR_IDX_PCFG       8'hC7
`define LFPTR_IDX_PAT0L      8'hC8
`define LFPTR_IDX_PAT1H      8'hCB
`define LFPTR_IDX_STATUS     8'hCC
`define LFPTR_IDX_DATA       8'hCD

`define LFPTR_CDM_DYN_HI     5
`define LFPTR_CDM_DYN_LO     4
`define LFPTR_CDM_CAL        3
`define LFPTR_CDM_FREEZE     2
`define LFPTR_RXC_RECAL      7
`define LFPTR_RXC_BBM_HI     5
`define LFPTR_RXC_BBM_LO     4
`define LFPTR_RXC_TIMER      3
`define LFPTR_RXC_RXEN       2
`define LFPTR_PCFG_SYNM      4
`define LFPTR_PCFG_PSL       1
`define LFPTR_PCFG_PSEL      0
`define LFPTR_ST_DECODE_ERROR_FLAG      6
`define LFPTR_ST_OVF         3
`define LFPTR_ST_SYNC        1
`define LFPTR_ST_MATCH       0

`define LFPTR_RST_CDM        8'h00
`define LFPTR_RST_PRECNT     8'h64
`define LFPTR_RST_ONOFF      8'h00
`define LFPTR_RST_PCFG       8'h00
`define LFPTR_RST_PAT        8'hFF

// 18-chip sync word, first chip in bit 17; holds non-Manchester pairs
`define LFPTR_SYNC_WORD      18'h3C3A5

`define LFPTR_CLK_PERIOD_NS  100
`define LFPTR_LP_PERIOD_NS   500000
`define LFPTR_CHIP_TIME_NS   128205
`define LFPTR_LP_CYCLES      (`LFPTR_LP_PERIOD_NS / `LFPTR_CLK_PERIOD_NS)
`define LFPTR_CHIP_CYCLES    (`LFPTR_CHIP_TIME_NS / `LFPTR_CLK_PERIOD_NS)

`endif

// File: lfptr_pkg.sv
// Purpose: Types shared by the LF telegram receiver modules
// Assumes: Nothing beyond the defines header
// Notes:   Baseband mode codes follow the two-bit mode field
package lfptr_pkg;

  typedef enum logic [1:0] {
    LFPTR_BBM_OFF,
    LFPTR_BBM_ALWAYS,
    LFPTR_BBM_CARRIER,
    LFPTR_BBM_RSVD
  } lfptr_bbm_e;

  typedef struct packed {
    logic       timer_en;
    logic       rx_en;
    lfptr_bbm_e bbm;
  } lfptr_rxc_s;

  typedef struct packed {
    logic sync_hit;
    logic bit_valid;
    logic bit_value;
    logic violation;
  } lfptr_dec_s;

endpackage

// File: lfptr_poll_timer.sv
// Purpose: On/off polling timer for the LF front end
// Assumes: lp_tick is a one-cycle pulse per low-power oscillator period
// Notes:   Settings are read live; change them while the timer is off
`timescale 1ns/10ps
module lfptr_poll_timer (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       lp_tick,
  input  wire logic       enable,
  input  wire logic [7:0] precount,
  input  wire logic [3:0] on_time,
  input  wire logic [3:0] off_time,
  output logic            on_phase
);
  import lfptr_pkg::*;

  logic [7:0] pre_reg;
  logic [5:0] unit_reg;
  logic [5:0] phase_reg;
  logic       run_reg;
  logic       tb_tick;
  logic       unit_end;

  assign tb_tick  = lp_tick && (pre_reg == precount); // R7
  assign unit_end = lp_tick && (unit_reg == precount[7:2]); // R9

  // Precounter restarts at each phase change so every off phase spans whole timebase ticks
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !enable || !run_reg) begin
      pre_reg <= 8'h00;
    end else if (tb_tick || (on_phase && unit_end && phase_reg[3:0] == on_time)) begin
      pre_reg <= 8'h00;
    end else if (lp_tick) begin
      pre_reg <= pre_reg + 8'h01; // R7
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !enable) begin
      run_reg   <= 1'b0;
      on_phase  <= 1'b0;
      unit_reg  <= 6'h00;
      phase_reg <= 6'h00;
    end else if (!run_reg) begin
      run_reg   <= 1'b1;
      on_phase  <= 1'b1; // R24
      unit_reg  <= 6'h00;
      phase_reg <= 6'h00;
    end else if (on_phase) begin
      if (unit_end) begin
        unit_reg <= 6'h00;
        if (phase_reg[3:0] == on_time) begin
          on_phase  <= 1'b0; // R5
          phase_reg <= 6'h00;
        end else begin
          phase_reg <= phase_reg + 6'h01; // R9
        end
      end else if (lp_tick) begin
        unit_reg <= unit_reg + 6'h01;
      end
    end else if (tb_tick) begin
      if (phase_reg == {off_time, 2'b11}) begin
        on_phase  <= 1'b1; // R24
        phase_reg <= 6'h00;
        unit_reg  <= 6'h00;
      end else begin
        phase_reg <= phase_reg + 6'h01; // R8
      end
    end
  end
endmodule

// File: lfptr_decoder.sv
// Purpose: Sync matcher and Manchester decoder on the sampled comparator chips
// Assumes: chip_tick is a one-cycle pulse per chip time, raw is already synchronised
// Notes:   No clock recovery; chip phase comes from a free divider
`timescale 1ns/10ps
`include "lfptr_defines.svh"
module lfptr_decoder (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              chip_tick,
  input  wire logic              raw,
  input  wire logic              active,
  output lfptr_pkg::lfptr_dec_s  dec
);
  import lfptr_pkg::*;

  typedef enum logic [1:0] {HUNT, FIRST_CHIP, SECOND_CHIP} lfptr_dstate_e;

  lfptr_dstate_e state_reg;
  logic [17:0]   chips_reg;
  logic          first_reg;

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !active) begin
      state_reg <= HUNT; // R19
      chips_reg <= 18'h00000;
      first_reg <= 1'b0;
      dec       <= '0;
    end else begin
      dec <= '0;
      if (chip_tick) begin
        chips_reg <= {chips_reg[16:0], raw};
        unique case (state_reg)
          HUNT: begin
            if ({chips_reg[16:0], raw} == `LFPTR_SYNC_WORD) begin
              state_reg    <= FIRST_CHIP; // R15
              dec.sync_hit <= 1'b1;
            end
          end
          FIRST_CHIP: begin
            first_reg <= raw;
            state_reg <= SECOND_CHIP;
          end
          SECOND_CHIP: begin
            if (raw == first_reg) begin
              dec.violation <= 1'b1; // R25
              state_reg     <= HUNT; // R19
            end else begin
              dec.bit_valid <= 1'b1;
              dec.bit_value <= first_reg; // R25
              state_reg     <= FIRST_CHIP;
            end
          end
        endcase
      end
    end
  end
endmodule

// File: lfptr_top_assertions.sv
// Purpose: Port checks of the LF telegram receiver
// Assumes: Reset is synchronous, active high
// Notes:   Bound into every lfptr_top
`timescale 1ns/10ps
module lfptr_top_assertions (
  input logic        sys_clk,
  input logic        sys_rst,
  input logic        s_axi_awready,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        frontend_on,
  input logic        calib_start,
  input logic        baseband_active,
  input logic        wakeup_pulse
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not cleared");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_write_after: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
    else $error("response before request");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_wake_single: assert property (wakeup_pulse |=> !wakeup_pulse)
    else $error("wakeup pulse too long");
  a_calib_single: assert property (calib_start |=> !calib_start)
    else $error("calibration pulse too long");
  a_bb_follow: assert property ($fell(frontend_on) |-> ##[0:3] !baseband_active)
    else $error("baseband left on");
  c_wake: cover property (wakeup_pulse);
  c_calib: cover property (calib_start);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

bind lfptr_top lfptr_top_assertions lfptr_top_assertions_inst (.*);

// File: lfptr_fe_model.sv
// Purpose: LF front end sending one telegram per start
// Assumes: CH clocks per chip
// Notes:   Idle comparator rests high, the inverse of the closing chip
`timescale 1ns/10ps
`include "lfptr_defines.svh"
module lfptr_fe_model #(parameter int CH = 4) (
  input  wire logic       sys_clk,
  input  wire logic       fe_on,
  input  wire logic       start,
  input  wire logic [7:0] id_byte,
  output logic            raw,
  output logic            carrier,
  output logic            busy
);
  logic [41:0] frame = '0;
  int          pos = 0;
  int          cnt = 0;
  initial raw = 1'b0;
  initial carrier = 1'b0;
  initial busy = 1'b0;
  function automatic logic [15:0] man(input logic [7:0] b);
    for (int i = 0; i < 8; i++) man[2 * i +: 2] = {b[i], ~b[i]};
  endfunction
  always @(posedge sys_clk) begin
    carrier <= busy && fe_on;
    if (start && !busy) begin
      // Equal-value preamble, sync, byte, then a violation pair ends the frame
      frame <= {6'h2A, `LFPTR_SYNC_WORD, man(id_byte), 2'b00};
      busy <= 1'b1;
      pos <= 41;
      cnt <= 0;
    end else if (busy && fe_on) begin
      raw <= frame[pos];
      cnt <= (cnt == CH - 1) ? 0 : cnt + 1;
      if (cnt == CH - 1 && pos == 0) busy <= 1'b0;
      else if (cnt == CH - 1) pos <= pos - 1;
    end else begin
      raw <= 1'b1;
    end
  end
endmodule

// File: lfptr_bench.sv
// Purpose: Self-checking bench of the LF telegram receiver
// Assumes: Oscillator and chip periods shortened to 4 clocks
// Notes:   Raw status bit is checked at the idle high level
`timescale 1ns/10ps
module lfptr_bench;
  localparam int LP = 4;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [9:0]  s_axi_awaddr = '0;
  logic [9:0]  s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        start = 1'b0;
  logic [7:0]  id_byte = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
  logic [1:0]  s_axi_bresp, s_axi_rresp, dynamic_threshold_sel;
  logic [31:0] s_axi_rdata;
  logic        raw_comparator_in, carrier_detect_in, frontend_on, calib_start, threshold_freeze;
  logic        baseband_active, wakeup_pulse, fe_prev = 1'b0;
  int          n_errors = 0, checks_done = 0, n_cal = 0, n_rise = 0, n_wake = 0;
  logic [7:0]  t_cfg[4] = '{8'h10, 8'h00, 8'h01, 8'h02};
  logic [7:0]  t_reg[4] = '{8'hC8, 8'hC8, 8'hCA, 8'hC8};
  logic [7:0]  t_pat[4] = '{8'hFF, 8'h5A, 8'h3C, 8'h5A};
  logic [7:0]  t_id[4] = '{8'hA5, 8'h5A, 8'h3C, 8'h5A};
  logic [7:0]  t_st[4] = '{8'h64, 8'h61, 8'h61, 8'h60};
  always #50 sys_clk = ~sys_clk;
  lfptr_top #(.LP_CYCLES(LP), .CHIP_CYCLES(4)) lfptr_top_inst (.*);
  lfptr_fe_model #(.CH(4)) lfptr_fe_model_inst (.sys_clk, .fe_on(frontend_on), .start, .id_byte,
    .raw(raw_comparator_in), .carrier(carrier_detect_in), .busy);
  always @(posedge sys_clk) begin
    fe_prev <= frontend_on;
    if (frontend_on && !fe_prev) n_rise++;
    if (calib_start) n_cal++;
    if (wakeup_pulse) n_wake++;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tmo;
    chk("timeout", 0, 1);
    finish_test();
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 100) tmo();
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 100) tmo();
    s_axi_rready <= 1'b0;
    chk($sformatf("reg %0h", idx), {24'h000000, e}, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic wait_fe(input logic v, output int n);
    for (n = 0; n < 3000 && frontend_on !== v; n++) @(posedge sys_clk);
    if (n == 3000) tmo();
  endtask
  initial begin
    int n, t_on, t_off, c0;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'hB5, 8'h00, 2'b00);
    rd(8'hC5, 8'h64, 2'b00);
    wr(8'hB5, 8'hFD, 2'b00);
    rd(8'hB5, 8'h3C, 2'b00);
    wr(8'hB5, 8'h14, 2'b00);
    chk("dyn_sel", 1, {30'h0, dynamic_threshold_sel});
    chk("freeze", 1, {31'h0, threshold_freeze});
    wr(8'h10, 8'h55, 2'b10);
    rd(8'h10, 8'h00, 2'b10);
    $display("test registers done");
    wr(8'hB5, 8'h18, 2'b00);
    wr(8'hC5, 8'h03, 2'b00);
    wr(8'hC6, 8'h01, 2'b00);
    wr(8'hC4, 8'h08, 2'b00);
    repeat (2) @(posedge sys_clk);
    chk("start_on", 1, {31'h0, frontend_on});
    wait_fe(1'b0, n);
    wait_fe(1'b1, n);
    wait_fe(1'b0, t_on);
    wait_fe(1'b1, t_off);
    chk("on_time", 2 * (3 / 4 + 1) * LP, t_on);
    chk("off_time", 4 * (3 + 1) * LP, t_off);
    wr(8'hC4, 8'h00, 2'b00);
    chk("calib_count", n_rise, n_cal);
    wr(8'hB5, 8'h10, 2'b00);
    c0 = n_cal;
    wr(8'hC4, 8'h24, 2'b00);
    repeat (4) @(posedge sys_clk);
    chk("mode2_idle", 0, {31'h0, baseband_active});
    wr(8'hC4, 8'h94, 2'b00);
    repeat (4) @(posedge sys_clk);
    chk("recal", c0 + 1, n_cal);
    chk("baseband", 1, {31'h0, baseband_active});
    rd(8'hC4, 8'h15, 2'b00);
    $display("test timer done");
    for (int i = 0; i < 4; i++) begin
      wr(8'hC7, t_cfg[i], 2'b00);
      wr(t_reg[i], t_pat[i], 2'b00);
      wr(8'hCC, 8'h4B, 2'b00);
      c0 = n_wake;
      id_byte <= t_id[i];
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
      repeat (2) @(posedge sys_clk);
      for (n = 0; n < 2000 && busy !== 1'b0; n++) @(posedge sys_clk);
      if (n == 2000) tmo();
      repeat (20) @(posedge sys_clk);
      rd(8'hCC, t_st[i], 2'b00);
      chk("wake", 1, {31'h0, n_wake > c0});
      if (i == 0) rd(8'hCD, 8'hA5, 2'b00);
    end
    wr(8'hC4, 8'h00, 2'b00);
    $display("test telegrams done");
    finish_test();
  end
endmodule
